// [src/bsw_burst_wait.sv]
// burst address sequencer, wait handshake and bus configuration register
`timescale 1ns/1ps
// How it works
// - fixed bursts of 4, 8, 16 or 32 words come from bits 2:0 and apply to reads and writes.
// - continuous burst is the default and steps sequentially, rolling over to zero at the top.
// - bit 3 low wraps a fixed burst inside its aligned block, bit 3 high (default) steps on.
// - without wrap the address steps linearly across boundaries and rolls over at the top.
// - with wrap the low address bits advance modulo the burst length from the start word.
// - bits 5:4 give full, half (default) or quarter drive, and 11 is reserved.
// - with bit 8 low, data goes valid or invalid on the same edge as wait changes.
// - with bit 8 high (default), wait changes one clock ahead of data valid or invalid.
// - bit 10 sets the asserted level of wait, high by default.
// - the bus configuration register loads its default value at reset.
// - reserved bits are written as zero by the host and all sixteen bits read back as written.
// - the register is selected by the select input high with address bits 19:18 at 10.
module bsw_burst_wait
(
   // clock and reset
   input  wire logic                          MCLK,
   input  wire logic                          RST_N,
   // register access through the select input
   input  wire bsw_pkg::bsw_reg_req_t         REG_REQ,
   input  wire logic                          REG_WRITE,
   input  wire logic                          REG_READ,
   output logic [bsw_pkg::DATA_W-1:0]         REG_RDATA,
   // software access sequence, one pulse per async access
   input  wire logic                          SW_STEP,
   input  wire logic                          SW_IS_WRITE,
   input  wire logic [bsw_pkg::ADDR_W-1:0]    SW_ADDR,
   input  wire logic [bsw_pkg::DATA_W-1:0]    SW_DATA,
   // burst control
   input  wire logic                          BURST_START,
   input  wire logic [bsw_pkg::ADDR_W-1:0]    BURST_START_ADDR,
   input  wire logic                          BURST_STOP,
   input  wire logic                          ARRAY_READY,
   // burst outputs
   output logic [bsw_pkg::ADDR_W-1:0]         BURST_ADDR,
   output logic                               DATA_VALID,
   output logic                               BURST_ACTIVE,
   output logic                               WAIT,
   output logic                               WAIT_OE,
   output logic [1:0]                         DRIVE_STRENGTH
);

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // mask of the address bits that wrap for a given length code
   function automatic logic [bsw_pkg::ADDR_W-1:0] len_mask(input logic [2:0] code);
      logic [bsw_pkg::ADDR_W-1:0] m;
      m = '0;
      case (code)
         bsw_pkg::LEN_4:  m = 22'h000003;
         bsw_pkg::LEN_8:  m = 22'h000007;
         bsw_pkg::LEN_16: m = 22'h00000F;
         bsw_pkg::LEN_32: m = 22'h00001F;
         default:         m = '0;
      endcase
      return m;
   endfunction

   // fixed length codes; reserved codes run as continuous
   function automatic logic is_fixed(input logic [2:0] code);
      return (code == bsw_pkg::LEN_4) || (code == bsw_pkg::LEN_8) ||
             (code == bsw_pkg::LEN_16) || (code == bsw_pkg::LEN_32);
   endfunction

   function automatic logic [bsw_pkg::ADDR_W-1:0] next_addr
   (
      input logic [bsw_pkg::ADDR_W-1:0] a,
      input logic                       wrap,
      input logic [bsw_pkg::ADDR_W-1:0] m
   );
      logic [bsw_pkg::ADDR_W-1:0] inc;
      inc = a + 22'h000001;
      if (wrap)
      begin
         return (a & ~m) | (inc & m);
      end
      return inc;
   endfunction

   // ----------------------------------------------------------------
   // bus configuration register
   // ----------------------------------------------------------------
   bsw_pkg::bsw_bus_config_t bus_configuration;
   bsw_pkg::bsw_state_t      state;
   logic [1:0]               sw_count;
   logic                     sw_bcr_selected;
   logic                     sel_hit;
   logic                     sw_hit;
   logic                     sw_ok;

   assign sel_hit = REG_REQ.select && (REG_REQ.addr_hi == bsw_pkg::SEL_BUS_CONFIGURATION);
   assign sw_ok   = SW_STEP && (SW_ADDR == bsw_pkg::SW_ACCESS_ADDR);
   assign sw_hit  = sw_ok && SW_IS_WRITE && (sw_count == bsw_pkg::SW_STEP_DATA)
                    && sw_bcr_selected;

   // software sequence: read, read, write select, write data
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         sw_count        <= 2'h0;
         sw_bcr_selected <= 1'b0;
      end
      else if (SW_STEP)
      begin
         if (!sw_ok)
         begin
            sw_count <= 2'h0;
         end
         else
         begin
            sw_count <= sw_count + 2'h1;
            if (sw_count == bsw_pkg::SW_STEP_SELECT)
            begin
               sw_bcr_selected <= SW_IS_WRITE && (SW_DATA == bsw_pkg::SW_SEL_BUS_CONFIG);
            end
         end
      end
   end

   // writes taken only while no burst runs, as the register changes in standby
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         bus_configuration <= bsw_pkg::BUS_CONFIGURATION_RESET;
      end
      else if (state == bsw_pkg::ST_IDLE)
      begin
         if (REG_WRITE && sel_hit)
         begin
            bus_configuration <= REG_REQ.data;
         end
         else if (sw_hit)
         begin
            bus_configuration <= SW_DATA;
         end
      end
   end

   // read data held in a flop; all sixteen bits come back as written
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         REG_RDATA <= '0;
      end
      else if (REG_READ && sel_hit)
      begin
         REG_RDATA <= bus_configuration;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         DRIVE_STRENGTH <= bsw_pkg::DRIVE_HALF;
      end
      else if (bus_configuration.drive_strength != bsw_pkg::DRIVE_RESERVED)
      begin
         DRIVE_STRENGTH <= bus_configuration.drive_strength;
      end
   end

   // ----------------------------------------------------------------
   // burst engine
   // ----------------------------------------------------------------
   logic [bsw_pkg::ADDR_W-1:0] cur_addr;
   logic [bsw_pkg::ADDR_W-1:0] addr_stage;
   logic [bsw_pkg::ADDR_W-1:0] mask;
   logic [bsw_pkg::CNT_W-1:0]  word_count;
   logic                       wrap;
   logic                       fixed;
   logic                       beat;
   logic                       last_beat;
   logic                       valid_stage;

   assign mask      = len_mask(bus_configuration.burst_length);
   assign fixed     = is_fixed(bus_configuration.burst_length);
   assign wrap      = fixed && !bus_configuration.burst_no_wrap;
   assign beat      = (state == bsw_pkg::ST_BURST) && ARRAY_READY && !BURST_STOP;
   assign last_beat = beat && fixed && (word_count == mask[bsw_pkg::CNT_W-1:0]);

   // drain lets the two pipeline stages empty before the wait pin is released
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         state <= bsw_pkg::ST_IDLE;
      end
      else
      begin
         case (state)
            bsw_pkg::ST_IDLE:
            begin
               if (BURST_START)
               begin
                  state <= bsw_pkg::ST_BURST;
               end
            end
            bsw_pkg::ST_BURST:
            begin
               if (BURST_STOP || last_beat)
               begin
                  state <= bsw_pkg::ST_DRAIN;
               end
            end
            bsw_pkg::ST_DRAIN:
            begin
               if (!valid_stage && !DATA_VALID)
               begin
                  state <= bsw_pkg::ST_IDLE;
               end
            end
            default:
            begin
               state <= bsw_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         cur_addr   <= '0;
         word_count <= '0;
      end
      else if (state == bsw_pkg::ST_IDLE && BURST_START)
      begin
         cur_addr   <= BURST_START_ADDR;
         word_count <= '0;
      end
      else if (beat)
      begin
         cur_addr   <= next_addr(cur_addr, wrap, mask);
         word_count <= word_count + 6'h01;
      end
   end

   // two stages: stage one feeds the late wait, stage two is the data beat
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         valid_stage <= 1'b0;
         addr_stage  <= '0;
         DATA_VALID  <= 1'b0;
         BURST_ADDR  <= '0;
      end
      else
      begin
         valid_stage <= beat;
         addr_stage  <= cur_addr;
         DATA_VALID  <= valid_stage;
         BURST_ADDR  <= addr_stage;
      end
   end

   // ----------------------------------------------------------------
   // wait pin
   // ----------------------------------------------------------------
   logic next_wait_asserted;
   logic next_oe;

   assign next_oe = (state != bsw_pkg::ST_IDLE) && !(state == bsw_pkg::ST_DRAIN
                    && !valid_stage && !DATA_VALID);

   // early mode follows the beat itself, late mode the first stage
   assign next_wait_asserted = bus_configuration.wait_config ? !beat
                                                             : !valid_stage;

   // host paces transfers on this level, so it is held in a flop
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         WAIT    <= 1'b0;
         WAIT_OE <= 1'b0;
      end
      else
      begin
         WAIT    <= bus_configuration.wait_polarity ? next_wait_asserted
                                                   : !next_wait_asserted;
         WAIT_OE <= next_oe;
      end
   end

   assign BURST_ACTIVE = (state != bsw_pkg::ST_IDLE);

endmodule

// [src/bsw_pkg.sv]
// shared constants and types for the burst sequence and wait configuration block
package bsw_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;
   localparam int CNT_W  = 6;

   // ----------------------------------------------------------------
   // register select and software sequence
   // ----------------------------------------------------------------
   localparam logic [1:0]        SEL_BUS_CONFIGURATION = 2'h2;
   localparam logic [DATA_W-1:0] SW_SEL_BUS_CONFIG     = 16'h0001;
   localparam logic [ADDR_W-1:0] SW_ACCESS_ADDR        = 22'h3FFFFF;
   localparam logic [1:0]        SW_STEP_SELECT        = 2'h2;
   localparam logic [1:0]        SW_STEP_DATA          = 2'h3;

   // ----------------------------------------------------------------
   // bus configuration register
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0] BUS_CONFIGURATION_RESET = 16'h9D1F;

   typedef struct packed {
      logic       operating_mode;   // [15]
      logic       initial_latency;  // [14]
      logic [2:0] latency_code;     // [13:11]
      logic       wait_polarity;    // [10]
      logic       reserved_9;       // [9]
      logic       wait_config;      // [8]
      logic [1:0] reserved_7_6;     // [7:6]
      logic [1:0] drive_strength;   // [5:4]
      logic       burst_no_wrap;    // [3]
      logic [2:0] burst_length;     // [2:0]
   } bsw_bus_config_t;

   // burst length codes
   localparam logic [2:0] LEN_4          = 3'h1;
   localparam logic [2:0] LEN_8          = 3'h2;
   localparam logic [2:0] LEN_16         = 3'h3;
   localparam logic [2:0] LEN_32         = 3'h4;
   localparam logic [2:0] LEN_CONTINUOUS = 3'h7;

   // drive strength codes
   localparam logic [1:0] DRIVE_FULL     = 2'h0;
   localparam logic [1:0] DRIVE_HALF     = 2'h1;
   localparam logic [1:0] DRIVE_QUARTER  = 2'h2;
   localparam logic [1:0] DRIVE_RESERVED = 2'h3;

   // burst engine states
   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_BURST = 2'h1,
      ST_DRAIN = 2'h3
   } bsw_state_t;

   // ----------------------------------------------------------------
   // register write request carrier
   // ----------------------------------------------------------------
   typedef struct packed {
      logic              select;   // register_select_input level
      logic [1:0]        addr_hi;  // address bits 19:18
      logic [DATA_W-1:0] data;
   } bsw_reg_req_t;

endpackage

// [tb/bsw_chk.sv]
// assertion checker for the burst sequence and wait block
`timescale 1ns/1ps
module bsw_chk
(
   // clock, reset and strobes
   input wire logic MCLK, RST_N, REG_WRITE, REG_READ, SW_STEP, SW_IS_WRITE,
   input wire logic BURST_START, BURST_STOP, DATA_VALID, BURST_ACTIVE, WAIT, WAIT_OE,
   // buses
   input wire bsw_pkg::bsw_reg_req_t REG_REQ,
   input wire logic [15:0] REG_RDATA, SW_DATA,
   input wire logic [21:0] SW_ADDR, BURST_START_ADDR, BURST_ADDR,
   input wire logic [1:0]  DRIVE_STRENGTH
);
   // ----------------------------------------------------------------
   // shadow of the configuration and the burst
   // ----------------------------------------------------------------
   logic [15:0] cfg;
   logic [1:0]  drv, sw_cnt;
   logic        sw_sel, stopped;
   logic [21:0] nxt;
   logic [6:0]  beats;
   wire hit = REG_REQ.select && REG_REQ.addr_hi == bsw_pkg::SEL_BUS_CONFIGURATION;
   wire sw_ok = SW_STEP && SW_ADDR == bsw_pkg::SW_ACCESS_ADDR;
   wire sw_ld = sw_ok && sw_cnt == 2'h3 && sw_sel && SW_IS_WRITE && !BURST_ACTIVE;
   wire ld = REG_WRITE && hit && !BURST_ACTIVE || sw_ld;
   wire [15:0] ld_d = REG_WRITE && hit ? REG_REQ.data : SW_DATA;
   wire fixed = cfg[2:0] != 3'h0 && cfg[2:0] <= 3'h4;
   wire [6:0] len = 7'h2 << cfg[2:0];
   wire [21:0] m = 22'(len) - 22'h1;

   always_ff @(posedge MCLK or negedge RST_N)
      if (!RST_N)
      begin
         cfg <= 16'h9D1F;
         drv <= 2'h1;
      end
      else if (ld)
      begin
         cfg <= ld_d;
         if (ld_d[5:4] != 2'h3) drv <= ld_d[5:4];
      end

   always_ff @(posedge MCLK or negedge RST_N)
      if (!RST_N)
         sw_cnt <= 2'h0;
      else if (SW_STEP)
         sw_cnt <= sw_ok ? sw_cnt + 2'h1 : 2'h0;

   always_ff @(posedge MCLK or negedge RST_N)
      if (!RST_N)
         sw_sel <= 1'b0;
      else if (sw_ok && sw_cnt == 2'h2)
         sw_sel <= SW_IS_WRITE && SW_DATA == bsw_pkg::SW_SEL_BUS_CONFIG;

   // no reset needed: every field is loaded at the start of a burst
   always_ff @(posedge MCLK)
      if (BURST_START && !BURST_ACTIVE)
      begin
         nxt <= BURST_START_ADDR;
         beats <= 7'h0;
         stopped <= 1'b0;
      end
      else
      begin
         if (DATA_VALID) nxt <= fixed && !cfg[3] ? BURST_ADDR & ~m | BURST_ADDR + 22'h1 & m
                                                 : BURST_ADDR + 22'h1;
         beats <= beats + 7'(DATA_VALID);
         stopped <= stopped | BURST_STOP;
      end

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   sequence go_s; BURST_START && !BURST_ACTIVE; endsequence
   sequence rd_hit_s; REG_READ && hit; endsequence

   start_act_a: assert property (go_s |=> BURST_ACTIVE)
      else $error("burst not active after start");
   beat_count_a: assert property ($fell(BURST_ACTIVE) && fixed && !stopped |->
      beats + 7'(DATA_VALID) == len) else $error("fixed burst word count wrong");
   burst_addr_a: assert property (DATA_VALID |-> BURST_ADDR == nxt)
      else $error("burst address out of sequence");
   wait_lead_a: assert property (cfg[8] && DATA_VALID |->
      $past(WAIT_OE) && $past(WAIT) != cfg[10]) else $error("wait not one clock ahead");
   wait_same_a: assert property (!cfg[8] && DATA_VALID |->
      WAIT_OE && WAIT != cfg[10]) else $error("wait not with data");
   wait_drop_a: assert property (cfg[8] && $past(WAIT_OE) && $past(WAIT) == cfg[10] |->
      !DATA_VALID) else $error("data valid after wait asserted");
   wait_hold_a: assert property (!cfg[8] && WAIT_OE && WAIT != cfg[10] |-> DATA_VALID)
      else $error("wait released without data");
   drive_a: assert property (!$past(ld) |-> DRIVE_STRENGTH == drv)
      else $error("drive strength wrong");
   read_back_a: assert property (rd_hit_s |=> REG_RDATA == $past(cfg))
      else $error("register read back wrong");
   read_miss_a: assert property (REG_READ && !hit |=> $stable(REG_RDATA))
      else $error("unselected read changed data");
endmodule

bind bsw_burst_wait bsw_chk i_chk (.MCLK(MCLK), .RST_N(RST_N), .REG_WRITE(REG_WRITE),
   .REG_READ(REG_READ), .SW_STEP(SW_STEP), .SW_IS_WRITE(SW_IS_WRITE),
   .BURST_START(BURST_START), .BURST_STOP(BURST_STOP), .DATA_VALID(DATA_VALID),
   .BURST_ACTIVE(BURST_ACTIVE), .WAIT(WAIT), .WAIT_OE(WAIT_OE), .REG_REQ(REG_REQ),
   .REG_RDATA(REG_RDATA), .SW_DATA(SW_DATA), .SW_ADDR(SW_ADDR),
   .BURST_START_ADDR(BURST_START_ADDR), .BURST_ADDR(BURST_ADDR),
   .DRIVE_STRENGTH(DRIVE_STRENGTH));

// [tb/bsw_host.sv]
// host controller model: starts bursts, counts words, stops continuous bursts
`timescale 1ns/1ps
module bsw_host
(
   input  wire logic        clk, rst_n, go, active,
   // wait pin as the host sees it, with the polarity and timing it configured
   input  wire logic        wait_in, wait_oe, pol, lead,
   input  wire logic [21:0] addr_in,
   input  wire logic [6:0]  n_stop,
   output logic             start, stop,
   output logic [21:0]      start_addr,
   output logic [6:0]       words
);
   // a word moves while wait shows data; in early mode one clock after that
   wire  data_ok = wait_oe && wait_in != pol;
   logic data_ok_d;

   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         data_ok_d <= 1'b0;
         start <= 1'b0;
         stop <= 1'b0;
         words <= 7'h0;
         start_addr <= 22'h0;
      end
      else
      begin
         start <= go && !active;
         // address is only meaningful with start, so it toggles otherwise
         start_addr <= go ? addr_in : ~start_addr;
         data_ok_d <= data_ok;
         words <= start ? 7'h0 : words + 7'(lead ? data_ok_d : data_ok);
         stop <= active && n_stop != 7'h0 && words >= n_stop;
      end
endmodule

// [tb/tb.sv]
// self-checking bench for the burst sequence and wait block
`timescale 1ns/1ps
module tb;
   logic mclk = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, go = 1'b0;
   logic sw_step = 1'b0, sw_is_write = 1'b0, arr_ready = 1'b0, dv, act, wt, wt_oe, bstart, bstop;
   logic [15:0] sw_data = 16'h0, rdata, mdl_cfg = 16'h9D1F;
   logic [21:0] sw_addr = 22'h3FFFFF, st_addr = 22'h0, bst_addr, baddr;
   logic [1:0] mdl_drv = 2'h1, drive;
   logic [6:0] n_stop = 7'h0, words;
   logic [31:0] seed = 32'h995C1D1C;
   bsw_pkg::bsw_reg_req_t req = '0;
   int miscompares = 0, n_tests = 0;
   logic [21:0] expq[$];
   localparam logic [47:0] CODES = 48'h715327443121;
   localparam logic [11:0] NOWRAP = 12'h4A4;

   always #2 mclk = ~mclk;

   bsw_burst_wait i_dut (.MCLK(mclk), .RST_N(rst_n), .REG_REQ(req), .REG_WRITE(reg_write),
      .REG_READ(reg_read), .REG_RDATA(rdata), .SW_STEP(sw_step), .SW_IS_WRITE(sw_is_write),
      .SW_ADDR(sw_addr), .SW_DATA(sw_data), .BURST_START(bstart), .BURST_START_ADDR(bst_addr),
      .BURST_STOP(bstop), .ARRAY_READY(arr_ready), .BURST_ADDR(baddr), .DATA_VALID(dv),
      .BURST_ACTIVE(act), .WAIT(wt), .WAIT_OE(wt_oe), .DRIVE_STRENGTH(drive));
   bsw_host i_host (.clk(mclk), .rst_n(rst_n), .go(go), .active(act), .wait_in(wt),
      .wait_oe(wt_oe), .pol(mdl_cfg[10]), .lead(mdl_cfg[8]), .addr_in(st_addr),
      .n_stop(n_stop), .start(bstart), .stop(bstop), .start_addr(bst_addr), .words(words));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // one register access; take says whether the model expects the write to land
   task automatic reg_acc(logic wr, logic sel, logic [1:0] hi, logic [15:0] d, logic take);
      @(posedge mclk);
      req <= {sel, hi, d};
      reg_write <= wr;
      reg_read <= !wr;
      @(posedge mclk);
      reg_write <= 1'b0;
      reg_read <= 1'b0;
      #1;
      if (take) mdl_cfg = d;
      if (take && d[5:4] != 2'h3) mdl_drv = d[5:4];
   endtask

   task automatic sw(logic wr, logic [15:0] d);
      @(posedge mclk);
      sw_step <= 1'b1;
      sw_is_write <= wr;
      sw_data <= d;
      @(posedge mclk);
      sw_step <= 1'b0;
   endtask

   // ----------------------------------------------------------------
   // one configured burst against the queue model
   // ----------------------------------------------------------------
   task automatic run(int i);
      logic [2:0] code;
      logic [21:0] s;
      int len;
      code = 3'(CODES >> (4 * i));
      len = code >= 3'h1 && code <= 3'h4 ? 2 << code : 0;
      reg_acc(1'b1, 1'b1, 2'h2, {5'h13, i[1] ^ i[2], 1'b0, i[0], 2'h0, 2'(i >> 1),
         NOWRAP[i], code}, 1'b1);
      reg_acc(1'b0, 1'b1, 2'h2, 16'h0, 1'b0);
      check("config readback", rdata, mdl_cfg);
      check("drive strength", drive, mdl_drv);
      s = i < 2 ? 22'h5 : i == 2 ? 22'h3 : i == 6 ? 22'h3FFFFE : 22'(xs());
      for (int k = 0; k < (len != 0 ? len : 64); k++)
         expq.push_back(22'(len != 0 && !NOWRAP[i] ? s & ~(len - 1) | s + k & len - 1 : s + k));
      @(posedge mclk);
      go <= 1'b1;
      st_addr <= s;
      n_stop <= len != 0 ? 7'h0 : 7'h6;
      @(posedge mclk);
      go <= 1'b0;
      repeat (4) @(posedge mclk);
      reg_acc(1'b1, 1'b1, 2'h2, 16'h0, 1'b0);
      for (int t = 0; t < 400 && act; t++)
         @(negedge mclk);
      repeat (2) @(negedge mclk);
      check("burst idle", act, 1'b0);
      check("words", len != 0 ? words : 7'(words >= 7'h6), len != 0 ? len : 1);
      check("words seen", words, (len != 0 ? len : 64) - expq.size());
      reg_acc(1'b0, 1'b1, 2'h2, 16'h0, 1'b0);
      check("write refused", rdata, mdl_cfg);
      expq.delete();
   endtask

   always @(posedge mclk)
      arr_ready <= xs() % 4 != 0;

   always @(negedge mclk)
      if (dv) check("burst address", baddr, expq.size() != 0 ? expq.pop_front() : ~baddr);

   initial
   begin
      #80000;
      miscompares++;
      complete_run();
   end

   initial
   begin
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      reg_acc(1'b0, 1'b1, 2'h2, 16'h0, 1'b0);
      check("reset config", rdata, 16'h9D1F);
      check("reset drive", drive, 2'h1);
      for (int i = 0; i < 12; i++)
         run(i);
      reg_acc(1'b1, 1'b0, 2'h2, 16'h1234, 1'b0);
      reg_acc(1'b0, 1'b1, 2'h1, 16'h0, 1'b0);
      reg_acc(1'b0, 1'b1, 2'h2, 16'h0, 1'b0);
      check("unselected write", rdata, mdl_cfg);
      // a foreign address restarts the count, a read as fourth step loads nothing
      sw(1'b0, 16'h0);
      sw(1'b0, 16'h0);
      sw(1'b1, 16'h0001);
      sw_addr <= 22'h0;
      sw(1'b1, 16'h0);
      sw_addr <= 22'h3FFFFF;
      sw(1'b0, 16'h0);
      sw(1'b0, 16'h0);
      sw(1'b1, 16'h0001);
      sw(1'b0, 16'h0);
      reg_acc(1'b0, 1'b1, 2'h2, 16'h0, 1'b0);
      check("software refused", rdata, mdl_cfg);
      sw(1'b0, 16'h0);
      sw(1'b0, 16'h0);
      sw(1'b1, 16'h0001);
      sw(1'b1, 16'h1D12);
      reg_acc(1'b0, 1'b1, 2'h2, 16'h0, 1'b0);
      check("software load", rdata, 16'h1D12);
      complete_run();
   end
endmodule
